//--- design/fdd_defines.svh
`ifndef FDD_DEFINES_SVH
`define FDD_DEFINES_SVH

`define FDD_OFS_DOUT      8'h00
`define FDD_OFS_FEN       8'h04
`define FDD_OFS_CCTL      8'h08
`define FDD_OFS_DRSEL     8'h0C
`define FDD_OFS_MODE      8'h10
`define FDD_OFS_STATA     8'h14

`define FDD_DOUT_SEL_LO   0
`define FDD_DOUT_SEL_HI   1
`define FDD_DOUT_DMAEN    3
`define FDD_DOUT_MTR_LO   4
`define FDD_FEN_ENC4      4
`define FDD_MODE_LO       0
`define FDD_MODE_HI       1
`define FDD_MODE_DOVR     4
`define FDD_MODE_DVAL     5
`define FDD_STA_UNIT2     0
`define FDD_STA_DRQ       1
`define FDD_STA_HEAD      2
`define FDD_STA_DENS      3

`define FDD_RST_BYTE      8'h00
`define FDD_RST_RATE      2'h0
`define FDD_RATE_500K     2'h0
`define FDD_RATE_1M       2'h3
`define FDD_SEL_NONE      2'h3

`endif

//--- design/fdd_pins.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "fdd_defines.svh"

module fdd_pins #(
	parameter int ADDR_W = 8
) (
	input  wire logic                 CLK_IN,
	input  wire logic                 NRST_IN,
	input  wire fdd_pkg::fdd_apb_req_t APB_REQ_IN,
	output fdd_pkg::fdd_apb_rsp_t     APB_RSP_OUT,
	input  wire logic                 DACK_N_IN,
	input  wire logic                 RD_N_IN,
	input  wire logic                 WR_N_IN,
	input  wire logic                 AEN_IN,
	output logic                      DRQ_OUT,
	output logic                      DMA_RD_OUT,
	output logic                      DMA_WR_OUT,
	input  wire logic                 XFER_NEED_IN,
	input  wire logic                 SEEK_ACTIVE_IN,
	input  wire logic                 STEP_INWARD_IN,
	input  wire logic                 RW_ACTIVE_IN,
	input  wire logic                 DRIVE_CLASS_IN,
	input  wire logic                 SECOND_UNIT_PRESENT_IN,
	output logic                      DENSITY_SELECT_OUT,
	output logic                      STEP_HEADING_OUT,
	output logic [1:0]                DRIVE_SEL_N_OUT,
	output logic [1:0]                RATE_CODE_OUT
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
		$error("fdd_pins: ADDR_W must be 5 to 8");
	end

	logic [7:0]              dout_reg;
	logic [7:0]              fen_reg;
	logic [1:0]              cctl_reg;
	logic [1:0]              drsel_reg;
	logic [7:0]              mode_reg;
	logic [1:0]              rate;
	logic                    pend;
	fdd_pkg::fdd_dma_state_t state;
	fdd_pkg::fdd_dma_state_t next_state;
	fdd_pkg::fdd_mode_t      mode;
	logic                    dma_en;
	logic                    ack_ok;
	logic                    strobe;
	logic                    wr_acc;
	logic                    rd_acc;
	logic [7:0]              addr;
	logic                    hit;
	logic [7:0]              stat_a;
	logic                    dens_hi;
	logic                    next_dens;
	logic [1:0]              next_sel_n;
	logic [1:0]              sel;
	logic                    mtr_on;

	assign addr   = APB_REQ_IN.paddr;
	assign wr_acc = APB_REQ_IN.psel & APB_REQ_IN.penable & APB_REQ_IN.pwrite;
	assign rd_acc = APB_REQ_IN.psel & APB_REQ_IN.penable & ~APB_REQ_IN.pwrite;
	assign hit    = (addr == `FDD_OFS_DOUT) || (addr == `FDD_OFS_FEN)
		|| (addr == `FDD_OFS_CCTL) || (addr == `FDD_OFS_DRSEL)
		|| (addr == `FDD_OFS_MODE) || (addr == `FDD_OFS_STATA);

	// compatibility mode; an unused code falls back to at_compat_mode behaviour
	always_comb begin
		case (mode_reg[`FDD_MODE_HI:`FDD_MODE_LO])
			2'h1:    mode = fdd_pkg::FDD_MODE_M30;
			2'h2:    mode = fdd_pkg::FDD_MODE_PS;
			default: mode = fdd_pkg::FDD_MODE_AT;
		endcase
	end

	// dma gate: bit 3 matters only outside ps_style_mode
	assign dma_en = (mode == fdd_pkg::FDD_MODE_PS) | dout_reg[`FDD_DOUT_DMAEN];
	assign ack_ok = ~DACK_N_IN & dma_en;
	// address and AEN play no part in the dma data path
	assign DMA_RD_OUT = ack_ok & ~RD_N_IN;
	assign DMA_WR_OUT = ack_ok & ~WR_N_IN;
	assign strobe     = DMA_RD_OUT | DMA_WR_OUT;

	// register writes
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			dout_reg  <= `FDD_RST_BYTE;
			fen_reg   <= `FDD_RST_BYTE;
			cctl_reg  <= `FDD_RST_RATE;
			drsel_reg <= `FDD_RST_RATE;
			mode_reg  <= `FDD_RST_BYTE;
		end else if (wr_acc) begin
			case (addr)
				`FDD_OFS_DOUT:  dout_reg  <= APB_REQ_IN.pwdata[7:0];
				`FDD_OFS_FEN:   fen_reg   <= APB_REQ_IN.pwdata[7:0];
				`FDD_OFS_CCTL:  cctl_reg  <= APB_REQ_IN.pwdata[1:0];
				`FDD_OFS_DRSEL: drsel_reg <= APB_REQ_IN.pwdata[1:0];
				`FDD_OFS_MODE:  mode_reg  <= APB_REQ_IN.pwdata[7:0];
				default: ;
			endcase
		end
	end

	// rate follows whichever rate register was written last
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN)
			rate <= `FDD_RST_RATE;
		else if (wr_acc && (addr == `FDD_OFS_CCTL || addr == `FDD_OFS_DRSEL))
			rate <= APB_REQ_IN.pwdata[1:0];
	end
	assign RATE_CODE_OUT = rate;

	// status A
	always_comb begin
		stat_a = 8'h00;
		stat_a[`FDD_STA_UNIT2] = (mode == fdd_pkg::FDD_MODE_PS) & SECOND_UNIT_PRESENT_IN;
		stat_a[`FDD_STA_DRQ]   = DRQ_OUT;
		stat_a[`FDD_STA_HEAD]  = STEP_HEADING_OUT;
		stat_a[`FDD_STA_DENS]  = DENSITY_SELECT_OUT;
	end

	// apb read path, zero wait states
	always_comb begin
		APB_RSP_OUT.pready  = 1'b1;
		APB_RSP_OUT.pslverr = APB_REQ_IN.psel & APB_REQ_IN.penable & ~hit;
		APB_RSP_OUT.prdata  = 32'h0000_0000;
		if (rd_acc) begin
			case (addr)
				`FDD_OFS_DOUT:  APB_RSP_OUT.prdata = {24'h000000, dout_reg};
				`FDD_OFS_FEN:   APB_RSP_OUT.prdata = {24'h000000, fen_reg};
				`FDD_OFS_CCTL:  APB_RSP_OUT.prdata = {30'h0000_0000, cctl_reg};
				`FDD_OFS_DRSEL: APB_RSP_OUT.prdata = {30'h0000_0000, drsel_reg};
				`FDD_OFS_MODE:  APB_RSP_OUT.prdata = {24'h000000, mode_reg};
				`FDD_OFS_STATA: APB_RSP_OUT.prdata = {24'h000000, stat_a};
				default:        APB_RSP_OUT.prdata = 32'h0000_0000;
			endcase
		end
	end

	// dma request handshake
	always_comb begin
		case (state)
			fdd_pkg::FDD_DMA_IDLE: next_state = (XFER_NEED_IN | pend) ?
				fdd_pkg::FDD_DMA_REQ : fdd_pkg::FDD_DMA_IDLE;
			fdd_pkg::FDD_DMA_REQ:  next_state = strobe ?
				fdd_pkg::FDD_DMA_XFER : fdd_pkg::FDD_DMA_REQ;
			fdd_pkg::FDD_DMA_XFER: next_state = strobe ?
				fdd_pkg::FDD_DMA_XFER : fdd_pkg::FDD_DMA_IDLE;
			default:               next_state = fdd_pkg::FDD_DMA_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN)
			state <= fdd_pkg::FDD_DMA_IDLE;
		else
			state <= next_state;
	end

	// a need arriving while busy is kept; in idle pend clears even if a new need arrives, since that need goes straight to request
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN)
			pend <= 1'b0;
		else if (XFER_NEED_IN && state != fdd_pkg::FDD_DMA_IDLE)
			pend <= 1'b1;
		else if (state == fdd_pkg::FDD_DMA_IDLE)
			pend <= 1'b0;
	end

	assign DRQ_OUT = (state == fdd_pkg::FDD_DMA_REQ) & dma_en;

	// density level
	assign dens_hi = (rate == `FDD_RATE_500K) | (rate == `FDD_RATE_1M);
	always_comb begin
		if (mode_reg[`FDD_MODE_DOVR])
			next_dens = mode_reg[`FDD_MODE_DVAL];
		else
			next_dens = DRIVE_CLASS_IN ? dens_hi : ~dens_hi;
	end

	// drive selects
	assign sel    = dout_reg[`FDD_DOUT_SEL_HI:`FDD_DOUT_SEL_LO];
	assign mtr_on = dout_reg[`FDD_DOUT_MTR_LO + sel];
	always_comb begin
		if (fen_reg[`FDD_FEN_ENC4])
			next_sel_n = mtr_on ? ~sel : `FDD_SEL_NONE;
		else begin
			next_sel_n = `FDD_SEL_NONE;
			if (!sel[1] && mtr_on)
				next_sel_n[sel[0]] = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			DENSITY_SELECT_OUT <= 1'b0;
			STEP_HEADING_OUT   <= 1'b0;
			DRIVE_SEL_N_OUT    <= `FDD_SEL_NONE;
		end else begin
			DENSITY_SELECT_OUT <= next_dens;
			STEP_HEADING_OUT   <= SEEK_ACTIVE_IN & STEP_INWARD_IN & ~RW_ACTIVE_IN;
			DRIVE_SEL_N_OUT    <= next_sel_n;
		end
	end

	property p_ack_gate;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(mode != fdd_pkg::FDD_MODE_PS && !dout_reg[`FDD_DOUT_DMAEN]) |-> !DMA_RD_OUT && !DMA_WR_OUT;
	endproperty
	a_ack_gate: assert property (p_ack_gate) else $error("dma strobe while gated");

	property p_ps_ack;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(mode == fdd_pkg::FDD_MODE_PS && !DACK_N_IN && !(RD_N_IN && WR_N_IN)) |-> strobe;
	endproperty
	a_ps_ack: assert property (p_ps_ack) else $error("ps mode ack not honoured");

	property p_drq_gate;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		DRQ_OUT |-> dma_en;
	endproperty
	a_drq_gate: assert property (p_drq_gate) else $error("request while gated");

	property p_drq_rise;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(state == fdd_pkg::FDD_DMA_IDLE && XFER_NEED_IN && dma_en) ##1 dma_en |-> DRQ_OUT;
	endproperty
	a_drq_rise: assert property (p_drq_rise) else $error("request late");

	property p_drq_drop;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(DRQ_OUT && strobe) |=> !DRQ_OUT;
	endproperty
	a_drq_drop: assert property (p_drq_drop) else $error("request not removed");

	property p_heading;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		RW_ACTIVE_IN |=> !STEP_HEADING_OUT;
	endproperty
	a_heading: assert property (p_heading) else $error("heading active in read or write");

	property p_rate;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(wr_acc && addr == `FDD_OFS_DRSEL) |=> RATE_CODE_OUT == $past(APB_REQ_IN.pwdata[1:0]);
	endproperty
	a_rate: assert property (p_rate) else $error("rate code not from last write");

	property p_onesel;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		!fen_reg[`FDD_FEN_ENC4] |=> DRIVE_SEL_N_OUT != 2'h0;
	endproperty
	a_onesel: assert property (p_onesel) else $error("two drives selected");

	property p_dens;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(!mode_reg[`FDD_MODE_DOVR] && dens_hi && DRIVE_CLASS_IN) |=> DENSITY_SELECT_OUT;
	endproperty
	a_dens: assert property (p_dens) else $error("density level wrong");

	property p_ack_idle;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		DACK_N_IN |-> !DMA_RD_OUT && !DMA_WR_OUT;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("strobe without ack");

	property p_ack_wr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(dma_en && !DACK_N_IN && !WR_N_IN) |-> DMA_WR_OUT;
	endproperty
	a_ack_wr: assert property (p_ack_wr) else $error("ack write lost");

	property p_aen_free;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(dma_en && !DACK_N_IN && !RD_N_IN && AEN_IN) |-> DMA_RD_OUT;
	endproperty
	a_aen_free: assert property (p_aen_free) else $error("aen blocked dma");

	property p_drq_mask;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(mode != fdd_pkg::FDD_MODE_PS && !dout_reg[`FDD_DOUT_DMAEN]) |-> !DRQ_OUT;
	endproperty
	a_drq_mask: assert property (p_drq_mask) else $error("request not masked");

	property p_ps_drq;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(mode == fdd_pkg::FDD_MODE_PS && state == fdd_pkg::FDD_DMA_REQ) |-> DRQ_OUT;
	endproperty
	a_ps_drq: assert property (p_ps_drq) else $error("ps request masked");

	property p_head_in;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(SEEK_ACTIVE_IN && STEP_INWARD_IN && !RW_ACTIVE_IN) |=> STEP_HEADING_OUT;
	endproperty
	a_head_in: assert property (p_head_in) else $error("heading not inward");

	property p_head_out;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		!STEP_INWARD_IN |=> !STEP_HEADING_OUT;
	endproperty
	a_head_out: assert property (p_head_out) else $error("heading not outward");

	property p_dens_inv;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(!mode_reg[`FDD_MODE_DOVR] && dens_hi && !DRIVE_CLASS_IN) |=> !DENSITY_SELECT_OUT;
	endproperty
	a_dens_inv: assert property (p_dens_inv) else $error("density polarity wrong");

	property p_dens_ovr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		mode_reg[`FDD_MODE_DOVR] |=> DENSITY_SELECT_OUT == $past(mode_reg[`FDD_MODE_DVAL]);
	endproperty
	a_dens_ovr: assert property (p_dens_ovr) else $error("density override lost");

	property p_rate_cctl;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(wr_acc && addr == `FDD_OFS_CCTL) |=> RATE_CODE_OUT == $past(APB_REQ_IN.pwdata[1:0]);
	endproperty
	a_rate_cctl: assert property (p_rate_cctl) else $error("rate code not from write");

	property p_sel_off;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		!mtr_on |=> DRIVE_SEL_N_OUT == `FDD_SEL_NONE;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("select without motor");

	property p_enc;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(fen_reg[`FDD_FEN_ENC4] && mtr_on) |=> DRIVE_SEL_N_OUT == ~$past(sel);
	endproperty
	a_enc: assert property (p_enc) else $error("encoded select wrong");

endmodule

//--- design/fdd_pkg.sv
package fdd_pkg;

	typedef enum logic [1:0] {
		FDD_MODE_AT  = 2'h0,
		FDD_MODE_M30 = 2'h1,
		FDD_MODE_PS  = 2'h2
	} fdd_mode_t;

	typedef enum logic [1:0] {
		FDD_DMA_IDLE = 2'h0,
		FDD_DMA_REQ  = 2'h1,
		FDD_DMA_XFER = 2'h2
	} fdd_dma_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} fdd_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} fdd_apb_rsp_t;

endpackage

//--- sim/fdd_dma_host_model.sv
`timescale 1ns/1ps
// host dma controller: answers a raised request after a short or long delay
module fdd_dma_host_model (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic drq_in,
	input  wire logic en_in,
	input  wire logic slow_in,
	input  wire logic rd_in,
	input  wire logic force_in,
	output logic      dack_n_out,
	output logic      rd_n_out,
	output logic      wr_n_out
);
	logic [3:0] phase;
	logic       act;
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			phase <= 4'h0;
		end else if (phase != 4'h0) begin
			phase <= phase - 4'h1;
		end else if (en_in && (drq_in || force_in)) begin
			phase <= slow_in ? 4'h6 : 4'h2;
		end
	end
	assign act        = (phase == 4'h1) || (phase == 4'h2);
	assign dack_n_out = !act;
	assign rd_n_out   = !(act && rd_in);
	assign wr_n_out   = !(act && !rd_in);
endmodule

//--- sim/test_floppy_dma_and_drive_signals.sv
`timescale 1ns/1ps
`include "fdd_defines.svh"
module test_floppy_dma_and_drive_signals;
	logic                  clk, dack_n, rd_n, wr_n, drq, dma_rd, dma_wr, dens, step, e;
	logic                  nrst = 1'b0, aen = 1'b0, need = 1'b0, seek = 1'b0, inw = 1'b0;
	logic                  rw = 1'b0, cls = 1'b0, unit2 = 1'b0, en = 1'b0, slow = 1'b0;
	logic                  hrd = 1'b1, frc = 1'b0;
	logic [1:0]            sel_n, rate;
	logic [31:0]           s, q, r, m;
	fdd_pkg::fdd_apb_req_t req = '0;
	fdd_pkg::fdd_apb_rsp_t rsp;
	int                    mismatches = 0, n_checks = 0, i;

	fdd_pins u_dut (.CLK_IN(clk), .NRST_IN(nrst), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
		.DACK_N_IN(dack_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n), .AEN_IN(aen), .DRQ_OUT(drq),
		.DMA_RD_OUT(dma_rd), .DMA_WR_OUT(dma_wr), .XFER_NEED_IN(need), .SEEK_ACTIVE_IN(seek),
		.STEP_INWARD_IN(inw), .RW_ACTIVE_IN(rw), .DRIVE_CLASS_IN(cls),
		.SECOND_UNIT_PRESENT_IN(unit2), .DENSITY_SELECT_OUT(dens), .STEP_HEADING_OUT(step),
		.DRIVE_SEL_N_OUT(sel_n), .RATE_CODE_OUT(rate));

	fdd_dma_host_model u_host (.clk_in(clk), .nrst_in(nrst), .drq_in(drq), .en_in(en),
		.slow_in(slow), .rd_in(hrd), .force_in(frc), .dack_n_out(dack_n), .rd_n_out(rd_n),
		.wr_n_out(wr_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rsp.pready !== 1'b1 && i < 20);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		if (i >= 20) begin
			mismatches++;
			test_done;
		end
	endtask

	task waitfor(input int k, input logic v);
		i = 0;
		while ((k == 0 ? drq : k == 1 ? dma_rd : dma_wr) !== v && i < 40) begin
			@(posedge clk);
			i++;
		end
		if (i >= 40) begin
			mismatches++;
			test_done;
		end
	endtask

	task pulse_need;
		@(posedge clk);
		need <= 1'b1;
		@(posedge clk);
		need <= 1'b0;
	endtask

	function automatic logic [1:0] exp_sel(input logic [7:0] d, input logic enc);
		logic [1:0] sl;
		sl = d[1:0];
		if (!d[4 + sl]) return 2'h3;
		if (enc) return ~sl;
		return sl == 2'h0 ? 2'h2 : sl == 2'h1 ? 2'h1 : 2'h3;
	endfunction

	function automatic logic exp_dens(input logic [1:0] rt, input logic c, input logic [31:0] md);
		logic hi;
		hi = rt == 2'h0 || rt == 2'h3;
		return md[4] ? md[5] : (c ? hi : !hi);
	endfunction

	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	initial begin
		s = 32'h04A7F702;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(sel_n, 2'h3);
		chk(drq, 1'b0);
		apb(1'b0, 8'h3C, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		for (int n = 0; n < 32; n++) begin
			r = rnd();
			m = {26'h0, r[21:20], 2'h0, r[19:18]};
			cls <= r[9];
			seek <= r[10];
			inw <= r[11];
			rw <= r[12];
			unit2 <= r[13];
			apb(1'b1, `FDD_OFS_FEN, {27'h0, r[8], 4'h0});
			apb(1'b1, `FDD_OFS_DOUT, {24'h0, r[7:0]});
			apb(1'b1, r[14] ? `FDD_OFS_CCTL : `FDD_OFS_DRSEL, {30'h0, r[16:15]});
			apb(1'b1, `FDD_OFS_MODE, m);
			repeat (2) @(posedge clk);
			chk(sel_n, exp_sel(r[7:0], r[8]));
			chk(rate, r[16:15]);
			chk(dens, exp_dens(r[16:15], r[9], m));
			chk(step, r[10] & r[11] & ~r[12]);
			apb(1'b0, `FDD_OFS_STATA, 32'h0);
			chk(q[0], (r[19:18] == 2'h2) ? r[13] : 1'b0);
			chk(q[3:1], {exp_dens(r[16:15], r[9], m), r[10] & r[11] & ~r[12], 1'b0});
			apb(1'b0, `FDD_OFS_DOUT, 32'h0);
			chk(q, {24'h0, r[7:0]});
		end
		apb(1'b1, `FDD_OFS_MODE, 32'h0);
		apb(1'b1, `FDD_OFS_DOUT, 32'h0);
		pulse_need;
		repeat (3) @(posedge clk);
		chk(drq, 1'b0);
		frc <= 1'b1;
		en <= 1'b1;
		repeat (4) begin
			@(posedge clk);
			chk(dma_rd, 1'b0);
		end
		frc <= 1'b0;
		en <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, `FDD_OFS_DOUT, 32'h08);
		waitfor(0, 1'b1);
		chk(drq, 1'b1);
		aen <= 1'b1;
		en <= 1'b1;
		waitfor(1, 1'b1);
		chk(dma_rd, 1'b1);
		@(posedge clk);
		chk(drq, 1'b0);
		en <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, `FDD_OFS_MODE, 32'h2);
		apb(1'b1, `FDD_OFS_DOUT, 32'h0);
		pulse_need;
		waitfor(0, 1'b1);
		chk(drq, 1'b1);
		hrd <= 1'b0;
		slow <= 1'b1;
		en <= 1'b1;
		waitfor(2, 1'b1);
		chk(dma_wr, 1'b1);
		@(posedge clk);
		chk(drq, 1'b0);
		test_done;
	end
endmodule
